/* File: code_fifo.sv */
module code_fifo #(
	parameter int WIDTH = 24,
	parameter int DEPTH = 8
) (
	input wire logic clock,
	input wire logic resetn,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_ptr;
	logic [AW-1:0] rd_ptr;
	logic [AW:0] count;
	wire push = in_valid && in_ready;
	wire load_out = (count != '0) && (!out_valid || out_ready);

	assign in_ready = (count != (AW+1)'(DEPTH));

	// storage, no reset on the array
	always_ff @(posedge clock)
	begin
		if (push)
			mem[wr_ptr] <= in_data;
	end

	always_ff @(posedge clock or negedge resetn)
	begin
		if (!resetn)
		begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count <= '0;
		end
		else
		begin
			if (push)
				wr_ptr <= wr_ptr + 1'b1;
			if (load_out)
				rd_ptr <= rd_ptr + 1'b1;
			count <= count + (AW+1)'(push) - (AW+1)'(load_out);
		end
	end

	// registered read stage
	always_ff @(posedge clock or negedge resetn)
	begin
		if (!resetn)
		begin
			out_valid <= 1'b0;
			out_data <= '0;
		end
		else if (load_out)
		begin
			out_valid <= 1'b1;
			out_data <= mem[rd_ptr];
		end
		else if (out_ready)
			out_valid <= 1'b0;
	end
endmodule // code_fifo

/* File: dac_host.sv */
module dac_host (
	output logic serial_clk,
	output logic chip_select_n,
	output logic serial_in,
	output logic load_strobe_a_n,
	output logic load_strobe_b_n
);
	timeunit 1ns;
	timeprecision 100ps;
	initial
	begin
		serial_clk = 1'b0;
		chip_select_n = 1'b1;
		serial_in = 1'b0;
		load_strobe_a_n = 1'b1;
		load_strobe_b_n = 1'b1;
	end
	// twelve bits msb first, clock idles low between frames
	task automatic send(input dac_pkg::code_t code, input logic sel_n);
		chip_select_n = sel_n;
		for (int i = 11; i >= 0; i--)
		begin
			serial_in = code[i];
			#62.5 serial_clk = 1'b1;
			#62.5 serial_clk = 1'b0;
		end
		serial_in = ~code[0];
		#62.5 chip_select_n = 1'b1;
		#62.5;
	endtask
	// one strobe low for one link period
	task automatic load(input logic to_b);
		load_strobe_a_n = to_b;
		load_strobe_b_n = ~to_b;
		#125;
		load_strobe_a_n = 1'b1;
		load_strobe_b_n = 1'b1;
		#125;
	endtask
endmodule // dac_host

/* File: dac_pkg.sv */
`include "dac_regs.svh"

package dac_pkg;
	typedef logic [`CODE_WIDTH-1:0] code_t;

	typedef struct packed {
		code_t a;
		code_t b;
	} codes_s;
endpackage

/* File: dac_regs.svh */
`ifndef DAC_REGS_SVH
`define DAC_REGS_SVH

`define CODE_WIDTH 12
`define PRESET_MID 12'h800
`define PRESET_ZERO 12'h000
`define FIFO_DEPTH 8

`define PIN_COUNT 8
`define PIN_SCLK 0
`define PIN_CS_N 1
`define PIN_DATA 2
`define PIN_LOAD_A_N 3
`define PIN_LOAD_B_N 4
`define PIN_PRESET_N 5
`define PIN_MID 6
`define PIN_PD_N 7
`define PIN_IDLE 8'hba

`endif

/* File: dual_dac_serial_load_logic.sv */
`include "dac_regs.svh"

module dual_dac_serial_load_logic (
	input wire logic clock,
	input wire logic resetn,
	input wire logic serial_clk,
	input wire logic chip_select_n,
	input wire logic serial_in,
	input wire logic load_strobe_a_n,
	input wire logic load_strobe_b_n,
	input wire logic preset_strobe_n,
	input wire logic midscale_select,
	input wire logic power_down_n,
	input wire logic converter_ready,
	output dac_pkg::code_t shift_word,
	output dac_pkg::codes_s dac_codes,
	output logic dac_update,
	output logic outputs_active,
	output logic update_stall
);
	logic [`PIN_COUNT-1:0] pins_raw;
	logic [`PIN_COUNT-1:0] pins_meta;
	logic [`PIN_COUNT-1:0] pins;
	logic sclk_prev;
	dac_pkg::codes_s target;
	dac_pkg::codes_s next_target;
	dac_pkg::codes_s sent;
	dac_pkg::codes_s fifo_out;
	logic fifo_in_ready;
	logic fifo_out_valid;
	localparam logic [`PIN_COUNT-1:0] pin_idle = `PIN_IDLE;

	assign pins_raw = {power_down_n, midscale_select, preset_strobe_n, load_strobe_b_n,
		load_strobe_a_n, serial_in, chip_select_n, serial_clk};

	// two-stage synchronisers, one per pin
	genvar gi;
	generate
		for (gi = 0; gi < `PIN_COUNT; gi++)
		begin : g_sync
			always_ff @(posedge clock or negedge resetn)
			begin
				if (!resetn)
				begin
					pins_meta[gi] <= pin_idle[gi];
					pins[gi] <= pin_idle[gi];
				end
				else
				begin
					pins_meta[gi] <= pins_raw[gi];
					pins[gi] <= pins_meta[gi];
				end
			end
		end
	endgenerate

	wire sclk_s = pins[`PIN_SCLK];
	wire cs_n_s = pins[`PIN_CS_N];
	wire data_s = pins[`PIN_DATA];
	wire load_a_n_s = pins[`PIN_LOAD_A_N];
	wire load_b_n_s = pins[`PIN_LOAD_B_N];
	wire preset_n_s = pins[`PIN_PRESET_N];
	wire mid_s = pins[`PIN_MID];
	wire pd_n_s = pins[`PIN_PD_N];

	// edge find on the sampled serial clock, gated by select
	wire sclk_rise = sclk_s && !sclk_prev;
	wire shift_en = sclk_rise && !cs_n_s;
	wire [`CODE_WIDTH-1:0] next_shift = {shift_word[`CODE_WIDTH-2:0], data_s};
	wire [`CODE_WIDTH-1:0] preset_value = mid_s ? `PRESET_MID : `PRESET_ZERO;

	always_ff @(posedge clock or negedge resetn)
	begin
		if (!resetn)
			sclk_prev <= 1'b0;
		else
			sclk_prev <= sclk_s;
	end

	// single shared shift register
	always_ff @(posedge clock or negedge resetn)
	begin
		if (!resetn)
			shift_word <= '0;
		else if (shift_en)
			shift_word <= next_shift;
	end

	// holding registers: preset first, strobes independent of select
	wire [`CODE_WIDTH-1:0] next_a = !preset_n_s ? preset_value :
		(!load_a_n_s ? shift_word : target.a);
	wire [`CODE_WIDTH-1:0] next_b = !preset_n_s ? preset_value :
		(!load_b_n_s ? shift_word : target.b);
	assign next_target = {next_a, next_b};

	always_ff @(posedge clock or negedge resetn)
	begin
		if (!resetn)
			target <= '0;
		else
			target <= next_target;
	end

	// forward changed codes toward the converter through the buffer
	wire push = (target != sent) && fifo_in_ready;
	assign update_stall = (target != sent) && !fifo_in_ready;

	always_ff @(posedge clock or negedge resetn)
	begin
		if (!resetn)
			sent <= '0;
		else if (push)
			sent <= target;
	end

	code_fifo #(
		.WIDTH(2*`CODE_WIDTH),
		.DEPTH(`FIFO_DEPTH)
	) u_fifo (
		.clock(clock),
		.resetn(resetn),
		.in_valid(push),
		.in_ready(fifo_in_ready),
		.in_data(target),
		.out_valid(fifo_out_valid),
		.out_ready(converter_ready),
		.out_data(fifo_out)
	);

	always_ff @(posedge clock or negedge resetn)
	begin
		if (!resetn)
		begin
			dac_codes <= '0;
			dac_update <= 1'b0;
		end
		else
		begin
			dac_update <= fifo_out_valid && converter_ready;
			if (fifo_out_valid && converter_ready)
				dac_codes <= fifo_out;
		end
	end

	// shutdown only reaches the analog side
	always_ff @(posedge clock or negedge resetn)
	begin
		if (!resetn)
			outputs_active <= 1'b0;
		else
			outputs_active <= pd_n_s;
	end

	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!resetn);

	sequence shift_edge_s;
		sclk_rise && !cs_n_s;
	endsequence

	sequence quiet_s;
		!shift_en [*2];
	endsequence

	sequence load_a_s;
		!load_a_n_s && preset_n_s;
	endsequence

	sequence load_b_s;
		!load_b_n_s && preset_n_s;
	endsequence

	sequence strobes_idle_s;
		load_a_n_s && load_b_n_s && preset_n_s;
	endsequence

	sequence preset_release_s;
		!preset_n_s ##1 strobes_idle_s;
	endsequence

	sequence deliver_s;
		fifo_out_valid && converter_ready;
	endsequence

	cs_blocks_shift_a: assert property (
		sclk_rise && cs_n_s |=>
		$stable(shift_word))
		else $error("shift register moved while deselected");

	select_spares_load_a: assert property (
		cs_n_s && !load_a_n_s && preset_n_s |=>
		target.a == $past(shift_word))
		else $error("select blocked a load");

	one_bit_shift_a: assert property (
		shift_edge_s |=>
		shift_word == {$past(shift_word[`CODE_WIDTH-2:0]), $past(data_s)})
		else $error("shift did not advance one bit");

	level_no_shift_a: assert property (
		quiet_s |->
		$stable(shift_word))
		else $error("shift register changed without a clock edge");

	no_edge_hold_a: assert property (
		!sclk_rise |=>
		$stable(shift_word))
		else $error("shift register changed on a steady clock level");

	direct_capture_a: assert property (
		shift_edge_s |=>
		shift_word[0] == $past(data_s))
		else $error("serial input not captured on the edge");

	strobe_hold_a: assert property (
		strobes_idle_s |=>
		$stable(target))
		else $error("holding register changed with strobes high");

	strobe_fall_load_a: assert property (
		$fell(load_a_n_s) && preset_n_s |=>
		target.a == $past(shift_word))
		else $error("strobe fall did not load channel a");

	load_a_follow_a: assert property (
		load_a_s |=>
		target.a == $past(shift_word))
		else $error("channel a not following shift register");

	a_spares_b_a: assert property (
		!load_a_n_s && load_b_n_s && preset_n_s |=>
		$stable(target.b))
		else $error("strobe a disturbed channel b");

	load_b_follow_a: assert property (
		load_b_s |=>
		target.b == $past(shift_word))
		else $error("channel b not following shift register");

	b_spares_a_a: assert property (
		!load_b_n_s && load_a_n_s && preset_n_s |=>
		$stable(target.a))
		else $error("strobe b disturbed channel a");

	preset_force_a: assert property (
		!preset_n_s [*2] |->
		target.a == $past(preset_value) && target.b == $past(preset_value))
		else $error("preset did not force both channels");

	preset_beats_load_a: assert property (
		!preset_n_s && !load_a_n_s |=>
		target.a == $past(preset_value))
		else $error("load strobe overrode the preset");

	preset_keep_a: assert property (
		preset_release_s |=>
		target.a == $past(preset_value, 2) && target.b == $past(preset_value, 2))
		else $error("preset value lost after release");

	preset_mid_a: assert property (
		!preset_n_s && mid_s |=>
		target.a == 12'h800 && target.b == 12'h800)
		else $error("midscale preset value wrong");

	preset_zero_a: assert property (
		!preset_n_s && !mid_s |=>
		target.a == 12'h000 && target.b == 12'h000)
		else $error("zero preset value wrong");

	shutdown_keep_a: assert property (
		!pd_n_s && !shift_en |=>
		$stable(shift_word))
		else $error("shutdown disturbed the shift register");

	shutdown_hold_a: assert property (
		!pd_n_s && load_a_n_s && load_b_n_s && preset_n_s |=>
		$stable(target))
		else $error("shutdown disturbed the holding registers");

	power_flag_a: assert property (
		!pd_n_s |=>
		!outputs_active)
		else $error("outputs still active in shutdown");

	shared_source_a: assert property (
		!load_a_n_s && !load_b_n_s && preset_n_s |=>
		target.a == target.b)
		else $error("channels loaded from different sources");

	forward_code_a: assert property (
		push |=>
		sent == $past(target))
		else $error("changed code not forwarded");

	stall_keeps_sent_a: assert property (
		update_stall |=>
		$stable(sent))
		else $error("code forwarded while buffer full");

	deliver_code_a: assert property (
		deliver_s |=>
		dac_update && dac_codes == $past(fifo_out))
		else $error("buffered code not delivered");

	no_deliver_hold_a: assert property (
		!(fifo_out_valid && converter_ready) |=>
		!dac_update && $stable(dac_codes))
		else $error("codes changed without a delivery");

	msb_first_a: assert property (
		shift_edge_s |=>
		shift_word[`CODE_WIDTH-1] == $past(shift_word[`CODE_WIDTH-2]))
		else $error("top bit not fed from the older bit");
endmodule // dual_dac_serial_load_logic

/* File: dual_dac_serial_load_logic_bench.sv */
module dual_dac_serial_load_logic_bench;
	timeunit 1ns;
	timeprecision 100ps;
	logic clock = 1'b0;
	logic resetn = 1'b0;
	logic preset_strobe_n = 1'b1;
	logic midscale_select = 1'b0;
	logic power_down_n = 1'b1;
	logic converter_ready = 1'b1;
	logic serial_clk, chip_select_n, serial_in, load_strobe_a_n, load_strobe_b_n;
	logic dac_update, outputs_active, update_stall;
	dac_pkg::code_t shift_word, a, b, c;
	dac_pkg::codes_s dac_codes;
	int n_fail = 0;
	int total_checks = 0;
	int n_updates = 0;
	int n_seen = 0;
	always #2 clock = ~clock;
	always @(negedge clock)
		if (dac_update)
			n_updates++;
	dac_host i_dac_host (.serial_clk(serial_clk), .chip_select_n(chip_select_n),
		.serial_in(serial_in), .load_strobe_a_n(load_strobe_a_n),
		.load_strobe_b_n(load_strobe_b_n));
	dual_dac_serial_load_logic i_dual_dac_serial_load_logic (.clock(clock), .resetn(resetn),
		.serial_clk(serial_clk), .chip_select_n(chip_select_n), .serial_in(serial_in),
		.load_strobe_a_n(load_strobe_a_n), .load_strobe_b_n(load_strobe_b_n),
		.preset_strobe_n(preset_strobe_n), .midscale_select(midscale_select),
		.power_down_n(power_down_n), .converter_ready(converter_ready),
		.shift_word(shift_word), .dac_codes(dac_codes), .dac_update(dac_update),
		.outputs_active(outputs_active), .update_stall(update_stall));
	function automatic dac_pkg::code_t preset_value(input logic mid);
		return mid ? 12'h800 : 12'h000;
	endfunction
	task automatic check(input string what, input logic [23:0] seen, input logic [23:0] exp);
		total_checks++;
		if (seen !== exp)
		begin
			n_fail++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic close_out();
		if (n_fail == 0 && total_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task automatic settle();
		repeat (12) @(posedge clock);
		#1;
	endtask
	initial
	begin
		#200000;
		n_fail++;
		close_out();
	end
	initial
	begin
		c = 12'($urandom(32'h8ae3));
		repeat (4) @(posedge clock);
		#1 resetn = 1'b1;
		check("reset codes", dac_codes, 24'h000000);
		for (int k = 0; k < 4; k++)
		begin
			a = (k == 0) ? 12'hfff : 12'($urandom);
			b = (k == 0) ? 12'h001 : 12'($urandom);
			i_dac_host.send(a, 1'b0);
			settle();
			check("shift_word", shift_word, a);
			i_dac_host.load(1'b0);
			settle();
			check("code a", dac_codes.a, a);
			i_dac_host.send(b, 1'b0);
			i_dac_host.send(~b, 1'b1);
			settle();
			check("shift deselected", shift_word, b);
			i_dac_host.load(1'b1);
			settle();
			check("codes", dac_codes, {a, b});
		end
		power_down_n = 1'b0;
		settle();
		check("active", outputs_active, 1'b0);
		check("down codes", dac_codes, {a, b});
		check("down shift", shift_word, b);
		power_down_n = 1'b1;
		converter_ready = 1'b0;
		for (int k = 0; k < 10; k++)
		begin
			c = 12'($urandom);
			i_dac_host.send(c, 1'b0);
			i_dac_host.load(k[0]);
			if (k[0])
				b = c;
			else
				a = c;
		end
		settle();
		check("stall", update_stall, 1'b1);
		converter_ready = 1'b1;
		repeat (4) settle();
		check("drained", dac_codes, {a, b});
		check("stall cleared", update_stall, 1'b0);
		check("active again", outputs_active, 1'b1);
		n_seen = n_updates;
		for (int m = 0; m < 2; m++)
		begin
			midscale_select = m[0];
			preset_strobe_n = 1'b0;
			settle();
			preset_strobe_n = 1'b1;
			settle();
			check("preset", dac_codes, {2{preset_value(m[0])}});
		end
		check("updates", 24'(n_updates - n_seen), 24'h000002);
		close_out();
	end
endmodule // dual_dac_serial_load_logic_bench
